/* File: scds_core.sv */
// Load-adaptive current regulation, driver status word and its interrupt logic.
// Notes on behaviour
// - When the load is at or above (threshold + hysteresis + 1) * 32 the current scale is lowered.
// - Each load sample that calls for more current raises the scale by 1, 2, 4 or 8 per the step code, at most to the run current.
// - When the load falls below threshold * 32 the current scale is raised.
// - A threshold of zero turns the load-adaptive regulation off.
// - Standstill is flagged 2^20 cycles after the last step pulse and cleared by the next step.
// - Open load is reported per phase and causes no protective action.
// - A ground short on a phase sets its flag and disables the power stage.
// - Short flags hold until off time is written zero or the disable pin is high.
// - One shared pre-warning bit follows the pre-warning temperature comparator.
// - Overtemperature sets a shared bit and keeps bridges off until pre-warning has cleared.
// - Stall is flagged from the stall detector input alone, not from the quiet-mode or full-step inputs.
// - The current scale in use is readable as a five-bit field.
// - Full-step-active follows the switch from microstepping to full-step drive.
// - The quiet-mode bit follows the silent voltage-mode chopper.
// - A supply short on a phase sets its flag and disables the driver until disabled.
`timescale 1ns/1ps
`include "scds_cfg.svh"
module scds_core
    import scds_pkg::*;
#(
    parameter int STST_CYCLES = `SCDS_STST_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic step_pulse,
    input wire logic load_valid,
    input wire logic [9:0] load_in,
    input wire logic driver_disable_pin,
    input wire logic [3:0] short_det,
    input wire logic [1:0] open_det,
    input wire logic otpw_det,
    input wire logic overtemp_det,
    input wire logic stall_det,
    input wire logic fullstep_mode,
    input wire logic quiet_mode,
    output logic bridge_enable,
    output logic [4:0] current_scale,
    output logic irq
);
    if (STST_CYCLES < 2) begin
        $error("STST_CYCLES must be at least 2");
    end

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Pins are asynchronous; the first stage feeds only the second.
    logic [9:0] pin_s1, pin_s2;
    logic [9:0] next_pin_s1;
    always_comb begin
        next_pin_s1 = {driver_disable_pin, short_det, open_det, otpw_det, overtemp_det, stall_det};
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 10'h200;
            pin_s2 <= 10'h200;
        end else begin
            pin_s1 <= next_pin_s1;
            pin_s2 <= pin_s1;
        end
    end
    logic dis_pin, otpw_s, overtemp_s, stall_s;
    logic [3:0] short_s;
    logic [1:0] open_s;
    assign dis_pin = pin_s2[9];
    assign short_s = pin_s2[8:5];
    assign open_s = pin_s2[4:3];
    assign otpw_s = pin_s2[2];
    assign overtemp_s = pin_s2[1];
    assign stall_s = pin_s2[0];

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [31:0] config_reg, control_reg;
    logic [7:0] irq_en;
    logic [31:0] next_config_reg, next_control_reg;
    logic [7:0] next_irq_en;
    logic [3:0] semin, semax, off_time_setting;
    logic [1:0] seup;
    logic [4:0] irun;
    assign semin = config_reg[`SCDS_SEMIN_LSB +: 4];
    assign seup = config_reg[`SCDS_SEUP_LSB +: 2];
    assign semax = config_reg[`SCDS_SEMAX_LSB +: 4];
    assign off_time_setting = control_reg[`SCDS_OFF_TIME_LSB +: 4];
    assign irun = control_reg[`SCDS_IRUN_LSB +: 5];
    always_comb begin
        next_config_reg = config_reg;
        next_control_reg = control_reg;
        next_irq_en = irq_en;
        if (wr && addr == `SCDS_OFF_CONFIG) begin
            next_config_reg = {17'h0, wdata[14:8], 1'b0, wdata[6:5], 1'b0, wdata[3:0]};
        end
        if (wr && addr == `SCDS_OFF_CONTROL) begin
            next_control_reg = {19'h0, wdata[12:8], 4'h0, wdata[3:0]};
        end
        if (wr && addr == `SCDS_OFF_IRQ_EN) begin
            next_irq_en = wdata[7:0];
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            config_reg <= `SCDS_CONFIG_RST;
            control_reg <= `SCDS_CONTROL_RST;
            irq_en <= 8'h00;
        end else begin
            config_reg <= next_config_reg;
            control_reg <= next_control_reg;
            irq_en <= next_irq_en;
        end
    end

    // ----------------------------------------------------------------
    // Protection flags
    // ----------------------------------------------------------------
    logic drv_off;
    assign drv_off = dis_pin || off_time_setting == 4'h0;
    scds_short_s shorts, next_shorts;
    logic overtemp_latch, next_overtemp_latch;
    always_comb begin
        next_shorts = shorts;
        if (drv_off) begin
            next_shorts = '0;
        end else begin
            next_shorts = shorts | short_s;
        end
        next_overtemp_latch = overtemp_latch;
        if (overtemp_s) begin
            next_overtemp_latch = 1'b1;
        end else if (!otpw_s) begin
            next_overtemp_latch = 1'b0;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shorts <= '0;
            overtemp_latch <= 1'b0;
        end else begin
            shorts <= next_shorts;
            overtemp_latch <= next_overtemp_latch;
        end
    end

    // ----------------------------------------------------------------
    // Standstill timer
    // ----------------------------------------------------------------
    logic [31:0] idle_cnt, next_idle_cnt;
    logic stst, next_stst;
    always_comb begin
        next_idle_cnt = idle_cnt;
        next_stst = stst;
        if (step_pulse) begin
            next_idle_cnt = 32'h0;
            next_stst = 1'b0;
        end else if (idle_cnt < 32'(STST_CYCLES - 1)) begin
            next_idle_cnt = idle_cnt + 32'h1;
        end else begin
            next_stst = 1'b1;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt <= 32'h0;
            stst <= 1'b0;
        end else begin
            idle_cnt <= next_idle_cnt;
            stst <= next_stst;
        end
    end

    // ----------------------------------------------------------------
    // Load-adaptive current scale
    // ----------------------------------------------------------------
    // Comparisons are made at 11 bits so the sum of thresholds cannot wrap.
    logic [9:0] load, next_load;
    logic [4:0] cs, next_cs;
    logic [10:0] lo_thr, hi_thr;
    logic [5:0] up_step, cs_sum;
    assign lo_thr = {2'b00, semin, 5'h00};
    assign hi_thr = {1'b0, 5'(semin + semax + 5'h1), 5'h00};
    assign up_step = 6'h1 << seup;
    assign cs_sum = {1'b0, cs} + up_step;
    always_comb begin
        next_load = load;
        next_cs = cs;
        if (load_valid) begin
            next_load = load_in;
        end
        if (semin == 4'h0) begin
            next_cs = irun;
        end else if (load_valid && {1'b0, load_in} < lo_thr) begin
            next_cs = cs_sum > {1'b0, irun} ? irun : cs_sum[4:0];
        end else if (load_valid && {1'b0, load_in} >= hi_thr && cs != 5'h0) begin
            next_cs = cs - 5'h1;
        end else if (cs > irun) begin
            next_cs = irun;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            load <= 10'h0;
            cs <= `SCDS_CS_MAX;
        end else begin
            load <= next_load;
            cs <= next_cs;
        end
    end

    // ----------------------------------------------------------------
    // Status word, interrupts and read port
    // ----------------------------------------------------------------
    scds_status_s status;
    always_comb begin
        status = '0;
        status.stst = stst;
        status.open_b = open_s[1];
        status.open_a = open_s[0];
        status.ground_short_phase_b = shorts.ground_b;
        status.ground_short_phase_a = shorts.ground_a;
        status.otpw = otpw_s;
        status.overtemp_shutdown = overtemp_latch;
        status.stall = stall_s;
        status.cs_actual = cs;
        status.fsactive = fullstep_mode;
        status.quiet = quiet_mode;
        status.supply_short_phase_b = shorts.supply_b;
        status.supply_short_phase_a = shorts.supply_a;
        status.load_measurement = load;
    end
    // Events: 0 stst, 1 ground short, 2 supply short, 3 pre-warning, 4 overtemp, 5 stall, 6 open load.
    logic [7:0] irq_stat, next_irq_stat, ev;
    logic [31:0] next_rdata;
    logic next_irq, next_bridge;
    always_comb begin
        ev = {1'b0, |open_s, stall_s, overtemp_latch, otpw_s, |shorts[1:0], |shorts[3:2], stst};
        next_irq_stat = irq_stat;
        if (wr && addr == `SCDS_OFF_IRQ_CLR) begin
            next_irq_stat = irq_stat & ~wdata[7:0];
        end
        next_irq_stat = next_irq_stat | ev;
        next_irq = |(next_irq_stat & irq_en);
        next_bridge = !drv_off && shorts == '0 && !overtemp_latch && !overtemp_s;
        next_rdata = 32'h0;
        if (rd) begin
            unique case (addr)
                `SCDS_OFF_STATUS: next_rdata = status;
                `SCDS_OFF_CONFIG: next_rdata = config_reg;
                `SCDS_OFF_CONTROL: next_rdata = control_reg;
                `SCDS_OFF_IRQ_STAT: next_rdata = {24'h0, irq_stat};
                `SCDS_OFF_IRQ_EN: next_rdata = {24'h0, irq_en};
                default: next_rdata = 32'h0;
            endcase
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat <= 8'h00;
            irq <= 1'b0;
            bridge_enable <= 1'b0;
            rdata <= 32'h0;
            current_scale <= 5'h0;
        end else begin
            irq_stat <= next_irq_stat;
            irq <= next_irq;
            bridge_enable <= next_bridge;
            rdata <= next_rdata;
            current_scale <= cs;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_short_off;
        @(posedge clock) disable iff (!rst_n) (shorts != '0) |=> !bridge_enable;
    endproperty
    a_short_off: assert property (p_short_off) else $error("bridge on with short latched");
    property p_short_clear;
        @(posedge clock) disable iff (!rst_n) drv_off |=> shorts == '0;
    endproperty
    a_short_clear: assert property (p_short_clear) else $error("short flag survived disable");
    property p_overtemp_hold;
        @(posedge clock) disable iff (!rst_n) (overtemp_latch && otpw_s) |=> overtemp_latch;
    endproperty
    a_overtemp_hold: assert property (p_overtemp_hold) else $error("overtemp released while warm");
    property p_stst_clear;
        @(posedge clock) disable iff (!rst_n) step_pulse |=> !stst;
    endproperty
    a_stst_clear: assert property (p_stst_clear) else $error("standstill after step");
    property p_off;
        @(posedge clock) disable iff (!rst_n) semin == 4'h0 |=> cs == $past(irun);
    endproperty
    a_off: assert property (p_off) else $error("scale moved while regulation off");
    property p_down;
        @(posedge clock) disable iff (!rst_n)
            semin != 4'h0 && load_valid && {1'b0, load_in} >= hi_thr && cs != 5'h0 && cs <= irun
            |=> cs == $past(cs) - 5'h1;
    endproperty
    a_down: assert property (p_down) else $error("scale not lowered at high load");
    property p_up;
        @(posedge clock) disable iff (!rst_n)
            semin != 4'h0 && load_valid && {1'b0, load_in} < lo_thr && cs_sum <= {1'b0, irun}
            |=> cs == 5'($past(cs) + (5'h1 << $past(seup)));
    endproperty
    a_up: assert property (p_up) else $error("scale not raised by step width");
    property p_load;
        @(posedge clock) disable iff (!rst_n)
            load_valid ##1 !load_valid ##1 (rd && addr == `SCDS_OFF_STATUS) |=> rdata[9:0] == $past(load_in, 3);
    endproperty
    a_load: assert property (p_load) else $error("load field mismatch");
    property p_rsv;
        @(posedge clock) disable iff (!rst_n)
            rd && addr == `SCDS_OFF_STATUS |=> rdata[23:21] == 3'h0 && rdata[11:10] == 2'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved status bits set");
endmodule

/* File: scds_cfg.svh */
// Register offsets, field positions, reset values and timing counts of the smart current block.
`ifndef SCDS_CFG_SVH
`define SCDS_CFG_SVH
`define SCDS_ADDR_W 8
`define SCDS_OFF_CONFIG 8'h6D
`define SCDS_OFF_CONTROL 8'h6C
`define SCDS_OFF_STATUS 8'h6F
`define SCDS_OFF_IRQ_STAT 8'h70
`define SCDS_OFF_IRQ_CLR 8'h71
`define SCDS_OFF_IRQ_EN 8'h72
`define SCDS_SEMIN_LSB 0
`define SCDS_SEUP_LSB 5
`define SCDS_SEMAX_LSB 8
`define SCDS_OFF_TIME_LSB 0
`define SCDS_IRUN_LSB 8
`define SCDS_CONFIG_RST 32'h0000_0000
`define SCDS_CONTROL_RST 32'h0000_1F03
`define SCDS_STST_CYCLES 1048576
`define SCDS_LOAD_UNIT 32
`define SCDS_CS_MAX 5'h1F
`endif

/* File: scds_pkg.sv */
// Types shared by the smart current and driver status block.
package scds_pkg;
    typedef struct packed {
        logic stst;
        logic open_b;
        logic open_a;
        logic ground_short_phase_b;
        logic ground_short_phase_a;
        logic otpw;
        logic overtemp_shutdown;
        logic stall;
        logic [2:0] rsv_hi;
        logic [4:0] cs_actual;
        logic fsactive;
        logic quiet;
        logic supply_short_phase_b;
        logic supply_short_phase_a;
        logic [1:0] rsv_lo;
        logic [9:0] load_measurement;
    } scds_status_s;
    typedef struct packed {
        logic ground_b;
        logic ground_a;
        logic supply_b;
        logic supply_a;
    } scds_short_s;
endpackage

/* File: scds_coil_model.sv */
// Behavioural model of the motor coils and sensors facing the smart current block.
`timescale 1ns/1ps
module scds_coil_model (
    input wire logic clock,
    output logic step_pulse,
    output logic load_valid,
    output logic [9:0] load_in,
    output logic [3:0] short_det,
    output logic [1:0] open_det,
    output logic otpw_det,
    output logic overtemp_det,
    output logic stall_det,
    output logic fullstep_mode,
    output logic quiet_mode
);
    initial begin
        {step_pulse, load_valid, short_det, open_det} = 8'h00;
        {otpw_det, overtemp_det, stall_det, fullstep_mode, quiet_mode} = 5'h00;
        load_in = 10'h155;
    end
    task automatic step();
        @(posedge clock);
        step_pulse <= 1'b1;
        @(posedge clock);
        step_pulse <= 1'b0;
    endtask
    // Between samples the bus carries the inverse, so a stale value never looks like a fresh one.
    task automatic sample(input logic [9:0] v);
        @(posedge clock);
        load_valid <= 1'b1;
        load_in <= v;
        @(posedge clock);
        load_valid <= 1'b0;
        load_in <= ~v;
    endtask
    // Levels are {otpw, ot, stall, fullstep, quiet}.
    task automatic faults(input logic [3:0] sh, input logic [1:0] op, input logic [4:0] lv);
        @(posedge clock);
        short_det <= sh;
        open_det <= op;
        {otpw_det, overtemp_det, stall_det, fullstep_mode, quiet_mode} <= lv;
    endtask
endmodule

/* File: tb_smart_current_and_driver_status.sv */
// Self-checking testbench of the smart current and driver status block.
`timescale 1ns/1ps
`include "scds_cfg.svh"
module tb_smart_current_and_driver_status;
    import scds_pkg::*;
    localparam int STST = 64;
    logic clock, rst_n, wr, rd, driver_disable_pin, bridge_enable, irq;
    logic step_pulse, load_valid, otpw_det, overtemp_det, stall_det, fullstep_mode, quiet_mode;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic [9:0] load_in;
    logic [3:0] short_det;
    logic [1:0] open_det;
    logic [4:0] current_scale;
    int error_cnt = 0;
    int checked = 0;
    scds_status_s st;
    scds_coil_model m (.clock(clock), .step_pulse(step_pulse), .load_valid(load_valid), .load_in(load_in),
        .short_det(short_det), .open_det(open_det), .otpw_det(otpw_det), .overtemp_det(overtemp_det),
        .stall_det(stall_det),
        .fullstep_mode(fullstep_mode), .quiet_mode(quiet_mode));
    scds_core #(.STST_CYCLES(STST)) dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .step_pulse(step_pulse), .load_valid(load_valid), .load_in(load_in),
        .driver_disable_pin(driver_disable_pin), .short_det(short_det), .open_det(open_det),
        .otpw_det(otpw_det), .overtemp_det(overtemp_det), .stall_det(stall_det), .fullstep_mode(fullstep_mode),
        .quiet_mode(quiet_mode), .bridge_enable(bridge_enable), .current_scale(current_scale), .irq(irq));
    // ----------------------------------------
    // Bus and comparison helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic rd_st();
        logic [31:0] d;
        rd_reg(`SCDS_OFF_STATUS, d);
        st = d;
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        logic [31:0] d;
        m.step();
        rd_st();
        chk(st.cs_actual, 5'h1F, "cs after reset");
        chk({st.rsv_hi, st.rsv_lo}, 0, "reserved bits");
        @(posedge clock);
        #1;
        chk(rdata, 0, "rdata after one cycle");
        wr_reg(`SCDS_OFF_STATUS, 32'hFFFF_FFFF);
        rd_reg(`SCDS_OFF_STATUS, d);
        chk(d, st, "status write ignored");
        rd_reg(`SCDS_OFF_CONFIG, d);
        chk(d, `SCDS_CONFIG_RST, "config reset");
        rd_reg(`SCDS_OFF_CONTROL, d);
        chk(d, `SCDS_CONTROL_RST, "control reset");
        rd_reg(8'h00, d);
        chk(d, 0, "unmapped read");
        $display("test regs done");
    endtask
    task automatic t_cool();
        int cs;
        wr_reg(`SCDS_OFF_CONFIG, 32'h0000_0102);
        cs = 31;
        for (int i = 0; i < 21; i++) begin
            m.sample(10'h080);
            cs--;
        end
        // One below the upper bound and exactly the lower bound leave the scale alone.
        m.sample(10'h07F);
        m.sample(10'h040);
        rd_st();
        chk(st.cs_actual, cs, "cs after down steps");
        chk(st.load_measurement, 10'h040, "load field");
        for (int k = 0; k < 4; k++) begin
            wr_reg(`SCDS_OFF_CONFIG, 32'h0000_0102 | (k << 5));
            m.sample(10'h03F);
            cs += 1 << k;
            wait_clk(2);
            chk(current_scale, cs, "up step width");
        end
        wr_reg(`SCDS_OFF_CONFIG, 32'h0000_0100);
        m.sample(10'h3FF);
        wait_clk(2);
        chk(current_scale, 5'h1F, "regulation off");
        $display("test regulation done");
    endtask
    task automatic t_stst();
        logic [31:0] d;
        m.step();
        wr_reg(`SCDS_OFF_IRQ_CLR, 32'h0000_00FF);
        wr_reg(`SCDS_OFF_IRQ_EN, 32'h0000_0001);
        wait_clk(STST - 12);
        rd_st();
        chk(st.stst, 0, "standstill early");
        chk(irq, 0, "irq early");
        wait_clk(16);
        rd_st();
        chk(st.stst, 1, "standstill set");
        chk(irq, 1, "irq on standstill");
        rd_reg(`SCDS_OFF_IRQ_STAT, d);
        chk(d[0], 1, "sticky standstill");
        wr_reg(`SCDS_OFF_IRQ_CLR, 32'h0000_0001);
        rd_reg(`SCDS_OFF_IRQ_STAT, d);
        chk(d[0], 1, "set wins over clear");
        wr_reg(`SCDS_OFF_IRQ_EN, 32'h0000_0000);
        wait_clk(2);
        chk(irq, 0, "irq masked");
        m.step();
        wait_clk(2);
        rd_st();
        chk(st.stst, 0, "standstill cleared");
        wr_reg(`SCDS_OFF_IRQ_CLR, 32'h0000_0001);
        wr_reg(`SCDS_OFF_IRQ_EN, 32'h0000_0001);
        wait_clk(2);
        chk(irq, 0, "irq cleared");
        $display("test standstill done");
    endtask
    task automatic t_short();
        chk(bridge_enable, 1, "bridge on");
        m.faults(4'b0100, 2'b00, 5'h00);
        wait_clk(6);
        chk(bridge_enable, 0, "ground short stops bridge");
        m.faults(4'b0000, 2'b00, 5'h00);
        wait_clk(6);
        rd_st();
        chk(st.ground_short_phase_a, 1, "ground flag held");
        chk(bridge_enable, 0, "bridge stays off");
        wr_reg(`SCDS_OFF_CONTROL, 32'h0000_1F00);
        wr_reg(`SCDS_OFF_CONTROL, 32'h0000_1F03);
        wait_clk(4);
        rd_st();
        chk(st.ground_short_phase_a, 0, "ground flag cleared");
        m.faults(4'b0010, 2'b00, 5'h00);
        wait_clk(6);
        rd_st();
        chk(st.supply_short_phase_b, 1, "supply flag");
        chk(bridge_enable, 0, "supply short stops bridge");
        m.faults(4'b0000, 2'b00, 5'h00);
        driver_disable_pin <= 1'b1;
        wait_clk(6);
        driver_disable_pin <= 1'b0;
        wait_clk(6);
        rd_st();
        chk(st.supply_short_phase_b, 0, "pin clears flag");
        chk(bridge_enable, 1, "bridge back on");
        $display("test shorts done");
    endtask
    task automatic t_temp();
        logic [31:0] d;
        m.faults(4'b0000, 2'b11, 5'b11000);
        wait_clk(6);
        rd_st();
        chk({st.otpw, st.overtemp_shutdown}, 2'b11, "temperature bits");
        chk(bridge_enable, 0, "overtemp stops bridge");
        m.faults(4'b0000, 2'b11, 5'b10000);
        wait_clk(6);
        chk(bridge_enable, 0, "waits for prewarning");
        m.faults(4'b0000, 2'b11, 5'b00111);
        wait_clk(6);
        rd_st();
        chk(bridge_enable, 1, "open load no action");
        chk({st.open_b, st.open_a}, 2'b11, "open load bits");
        chk(st.stall, 1, "stall bit");
        chk({st.fsactive, st.quiet}, 2'b11, "mode bits");
        m.faults(4'b0000, 2'b00, 5'b00000);
        wait_clk(4);
        rd_st();
        chk({st.fsactive, st.quiet, st.otpw}, 0, "mode bits clear");
        rd_reg(`SCDS_OFF_IRQ_STAT, d);
        chk(d[7:1], 7'h3F, "event bits sticky");
        $display("test temperature done");
    endtask
    // ----------------------------------------
    // Clock, reset, sequence and verdict
    // ----------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        {rst_n, wr, rd, driver_disable_pin} = 4'h0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        wait_clk(4);
        t_regs();
        t_cool();
        t_stst();
        t_short();
        t_temp();
        give_verdict();
    end
    // The whole run needs well under a thousand cycles.
    initial begin
        #40000;
        error_cnt++;
        give_verdict();
    end
endmodule
